// >>> logic/ric_defs.svh
// Overview of operation
// - Two reset sources, power-on and pin low; watchdog reset pulls the pin low.
// - Any reset fetches the vector at 1FFE/1FFF into the program counter.
// - Power-on waits 4096 clocks of oscillator activity before leaving reset.
// - During power-on reset the reset pin is driven low.
// - After the power-on delay, reset persists while the pin is low.
// - Power-on reset only on a rising supply; no reset on a supply drop.
// - Service pushes PC, X, A, CC, then sets the mask; Y is not saved.
// - Return pops the stacked registers; mask clears only if stacked bit was zero.
// - Grant order: trap, pin, capture, compare, overflow, wake; reset above all.
// - Trap is taken regardless of mask; only trap accepted while masked.
// - Masked requests stay pending and are serviced once enabled.
// - Trigger selection changes only while the mask is set.
// - Changing trigger selection drops a pending external request.
// - Edges latch as pending; low-level requests are never latched.
// - External pending latch holds one request and clears at service start.
// - Interrupts are taken only at an instruction boundary.
// - Wired sources: line still low after service raises another request.
// - Falling edge on any enabled wake pin raises the wake interrupt.
// - Resets clear peripherals, set SP to 00FF, timer FFFC, set mask, clear bits.
// - Power-on and halt exit stop the clock 4096 clocks; wait/halt clear the mask.
// - Trigger code: 00 fall+low, fall bit fall, rise bit rise, both both edges.
// - Each source has its own vector; external pin at 1FFA/1FFB.
`ifndef RIC_DEFS_SVH
`define RIC_DEFS_SVH
`define RIC_VEC_RESET 13'h1ffe
`define RIC_VEC_TRAP 13'h1ffc
`define RIC_VEC_EXT 13'h1ffa
`define RIC_VEC_CAP 13'h1ff8
`define RIC_VEC_CMP 13'h1ff6
`define RIC_VEC_OVF 13'h1ff4
`define RIC_VEC_WAKE 13'h1ff0
`define RIC_SP_RESET 8'hff
`define RIC_TMR_RESET 16'hfffc
`define RIC_STARTUP_CYC 4096
`define RIC_RST_MIN_HALF_CYC 3
`define RIC_WATCHDOG_CONTROL_BIT_PULSE_CYC ((`RIC_RST_MIN_HALF_CYC + 1) / 2)
`define RIC_CC_I_BIT 3
`define RIC_MISC_RISE_BIT 6
`define RIC_MISC_FALL_BIT 5
`define RIC_MISC_SM_BIT 1
`define RIC_MISC_WATCHDOG_CONTROL_BIT_BIT 0
`define RIC_PUSH_LAST 3'h4
`define RIC_POP_LAST 3'h6
`define RIC_SYNC_W 10
`define RIC_SYNC_RST 10'h0ff
`endif

// >>> logic/ric_pkg.sv
package ric_pkg;
  typedef enum logic [11:0] {
    ST_POR = 12'h001,
    ST_RSTHOLD = 12'h002,
    ST_RUN = 12'h004,
    ST_PUSH = 12'h008,
    ST_FETCH_A = 12'h010,
    ST_FETCH_B = 12'h020,
    ST_FETCH_C = 12'h040,
    ST_FETCH_D = 12'h080,
    ST_POP = 12'h100,
    ST_WAIT = 12'h200,
    ST_HALT = 12'h400,
    ST_WAKE = 12'h800
  } ric_state_t;
  typedef logic [12:0] ric_addr_t;
  typedef logic [7:0] ric_byte_t;
endpackage

// >>> logic/ric_pin_if.sv
`timescale 1ns/1ps
interface ric_pin_if #(parameter int W = 10);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_mp (input raw, output clean);
  modport user_mp (output raw, input clean);
endinterface

// >>> logic/ric_pin_sync.sv
`timescale 1ns/1ps
module ric_pin_sync #(
  parameter int W = 10,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  ric_pin_if.sync_mp pins
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_r, s2_r, s3_r, out_r;
      // Three stages; only the agreeing later pair updates the output
      always_ff @(posedge i_core_clk)
      begin
        if (i_rst)
        begin
          s1_r <= RST_VAL[g];
          s2_r <= RST_VAL[g];
          s3_r <= RST_VAL[g];
          out_r <= RST_VAL[g];
        end
        else if (i_ce)
        begin
          s1_r <= pins.raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            out_r <= s3_r;
        end
      end
      assign pins.clean[g] = out_r;
    end
  endgenerate
endmodule // ric_pin_sync

// >>> logic/ric_reset_int_ctrl.sv
`timescale 1ns/1ps
`include "ric_defs.svh"
module ric_reset_int_ctrl #(
  parameter int POR_CYCLES = `RIC_STARTUP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_supply_ok,
  input wire logic i_osc_active,
  input wire logic i_reset_pin_n,
  output logic o_reset_pin_o,
  output logic o_reset_pin_oe,
  input wire logic i_watchdog_control_bit_expire,
  input wire logic i_ext_int_pin,
  input wire logic [5:0] i_wake_port_pins,
  input wire logic [5:0] i_wake_src_en,
  input wire logic i_tmr_capture,
  input wire logic i_tmr_compare,
  input wire logic i_tmr_overflow,
  input wire logic i_instr_end,
  input wire logic i_trap_exec,
  input wire logic i_return_from_interrupt,
  input wire logic i_wait_exec,
  input wire logic i_halt_exec,
  input wire logic i_mask_wr,
  input wire logic i_mask_val,
  input wire logic i_misc_wr,
  input wire ric_pkg::ric_byte_t i_misc_wdata,
  input wire ric_pkg::ric_addr_t i_pc,
  input wire ric_pkg::ric_byte_t i_x,
  input wire ric_pkg::ric_byte_t i_a,
  input wire logic [4:0] i_cc,
  input wire ric_pkg::ric_byte_t i_mem_rdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output ric_pkg::ric_addr_t o_mem_addr,
  output ric_pkg::ric_byte_t o_mem_wdata,
  output logic o_pc_load,
  output logic o_regs_restore,
  output ric_pkg::ric_addr_t o_pc,
  output ric_pkg::ric_byte_t o_x,
  output ric_pkg::ric_byte_t o_a,
  output logic [4:0] o_cc,
  output ric_pkg::ric_byte_t o_sp,
  output logic o_int_mask,
  output logic o_rising_trigger_select,
  output logic o_falling_trigger_select,
  output logic o_slow_clock_bit,
  output logic o_watchdog_control_bit,
  output logic o_sys_reset,
  output logic [15:0] o_timer_preset,
  output logic o_cpu_hold,
  output logic o_clk_stop,
  output logic o_wait_latch,
  output logic o_halt_latch
);
  import ric_pkg::*;
  localparam int CW = $clog2(POR_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edges
  ric_pin_if #(.W(`RIC_SYNC_W)) pins ();
  assign pins.raw = {i_osc_active, i_supply_ok, i_wake_port_pins, i_ext_int_pin, i_reset_pin_n};

  ric_pin_sync #(
    .W(`RIC_SYNC_W),
    .RST_VAL(`RIC_SYNC_RST)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .pins(pins)
  );

  logic [9:0] prev_r;
  logic pin_hi, osc_on, sup_rise, ext_fall, ext_rise, ext_edge, ext_req, wake_set;
  logic [5:0] wake_fall;
  logic [1:0] trig;
  ric_state_t state_r, state_nxt;
  ric_addr_t base_r, base_nxt, grant_base;
  logic grant_any, in_rst, dly_done, run_end, trig_chg, halt_watchdog_control_bit, svc_start;
  logic [2:0] step_r;
  logic [CW-1:0] dly_cnt_r;
  logic [1:0] watchdog_control_bit_cnt_r;
  logic i_bit_r, ext_pend_r, wake_pend_r;
  logic rise_sel_r, fall_sel_r, sm_r, watchdog_control_bit_r;
  ric_byte_t sp_r, push_data;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      prev_r <= `RIC_SYNC_RST;
    else if (i_ce)
      prev_r <= pins.clean;
  end

  assign pin_hi = pins.clean[0];
  assign osc_on = pins.clean[9];
  // Only a rising supply starts power-on; a drop is ignored
  assign sup_rise = pins.clean[8] & ~prev_r[8];
  assign ext_fall = prev_r[1] & ~pins.clean[1];
  assign ext_rise = ~prev_r[1] & pins.clean[1];
  assign wake_fall = prev_r[7:2] & ~pins.clean[7:2];
  assign trig = {rise_sel_r, fall_sel_r};

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification
  always_comb
  begin
    ext_edge = 1'b0;
    case (trig)
      2'h0, 2'h1: ext_edge = ext_fall;
      2'h2: ext_edge = ext_rise;
      default: ext_edge = ext_fall | ext_rise;
    endcase
  end

  // Low level asks live and is never latched
  assign ext_req = ext_pend_r | (trig == 2'h0 && !pins.clean[1]);
  assign wake_set = |(wake_fall & i_wake_src_en);

  always_comb
  begin
    grant_any = 1'b1;
    grant_base = `RIC_VEC_RESET;
    if (ext_req)
      grant_base = `RIC_VEC_EXT;
    else if (i_tmr_capture)
      grant_base = `RIC_VEC_CAP;
    else if (i_tmr_compare)
      grant_base = `RIC_VEC_CMP;
    else if (i_tmr_overflow)
      grant_base = `RIC_VEC_OVF;
    else if (wake_pend_r)
      grant_base = `RIC_VEC_WAKE;
    else
      grant_any = 1'b0;
  end

  assign in_rst = state_r == ST_POR || state_r == ST_RSTHOLD;
  assign dly_done = dly_cnt_r == CW'(POR_CYCLES - 1);
  assign run_end = state_r == ST_RUN && i_instr_end;
  assign halt_watchdog_control_bit = run_end && i_halt_exec && watchdog_control_bit_r;
  assign trig_chg = i_misc_wr && i_bit_r &&
    i_misc_wdata[`RIC_MISC_RISE_BIT:`RIC_MISC_FALL_BIT] != trig;
  assign svc_start = state_nxt == ST_PUSH && state_r != ST_PUSH;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    base_nxt = base_r;
    if (sup_rise)
      state_nxt = ST_POR;
    else if (state_r != ST_POR && !pin_hi)
      state_nxt = ST_RSTHOLD;
    else
    begin
      case (state_r)
        ST_POR:
          if (osc_on && dly_done)
            state_nxt = ST_RSTHOLD;
        ST_RSTHOLD:
        begin
          state_nxt = ST_FETCH_A;
          base_nxt = `RIC_VEC_RESET;
        end
        ST_RUN:
          if (i_instr_end)
          begin
            if (i_trap_exec)
            begin
              state_nxt = ST_PUSH;
              base_nxt = `RIC_VEC_TRAP;
            end
            else if (i_return_from_interrupt)
              state_nxt = ST_POP;
            else if (i_halt_exec && !watchdog_control_bit_r)
              state_nxt = ST_HALT;
            else if (i_wait_exec)
              state_nxt = ST_WAIT;
            else if (!i_bit_r && grant_any)
            begin
              state_nxt = ST_PUSH;
              base_nxt = grant_base;
            end
          end
        ST_WAIT:
          if (!i_bit_r && grant_any)
          begin
            state_nxt = ST_PUSH;
            base_nxt = grant_base;
          end
        ST_HALT:
          if (ext_req || wake_pend_r)
            state_nxt = ST_WAKE;
        ST_WAKE:
          if (dly_done)
          begin
            state_nxt = grant_any ? ST_PUSH : ST_RUN;
            base_nxt = grant_base;
          end
        ST_PUSH:
          if (step_r == `RIC_PUSH_LAST)
            state_nxt = ST_FETCH_A;
        ST_FETCH_A: state_nxt = ST_FETCH_B;
        ST_FETCH_B: state_nxt = ST_FETCH_C;
        ST_FETCH_C: state_nxt = ST_FETCH_D;
        ST_FETCH_D: state_nxt = ST_RUN;
        ST_POP:
          if (step_r == `RIC_POP_LAST)
            state_nxt = ST_RUN;
        default: state_nxt = ST_POR;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r <= ST_POR;
      base_r <= `RIC_VEC_RESET;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      base_r <= base_nxt;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      step_r <= 3'h0;
    else if (i_ce)
      step_r <= (state_nxt == state_r) ? step_r + 3'h1 : 3'h0;
  end

  // Clock-stop delay shared by power-on and halt exit
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      dly_cnt_r <= '0;
    else if (i_ce)
    begin
      if (sup_rise || state_nxt != state_r)
        dly_cnt_r <= '0;
      else if ((state_r == ST_POR && osc_on) || state_r == ST_WAKE)
        dly_cnt_r <= dly_cnt_r + CW'(1);
    end
  end

  // Watchdog drives the pin low; the pin then re-enters as a reset
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      watchdog_control_bit_cnt_r <= 2'h0;
    else if (i_ce)
    begin
      if (i_watchdog_control_bit_expire || halt_watchdog_control_bit)
        watchdog_control_bit_cnt_r <= 2'(`RIC_WATCHDOG_CONTROL_BIT_PULSE_CYC);
      else if (watchdog_control_bit_cnt_r != 2'h0)
        watchdog_control_bit_cnt_r <= watchdog_control_bit_cnt_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask and pending latches
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      i_bit_r <= 1'b1;
    else if (i_ce)
    begin
      if (in_rst)
        i_bit_r <= 1'b1;
      else if (state_nxt == ST_WAIT || state_nxt == ST_HALT)
        i_bit_r <= 1'b0;
      else if (state_r == ST_PUSH && step_r == `RIC_PUSH_LAST)
        i_bit_r <= 1'b1;
      else if (state_r == ST_POP && step_r == 3'h2)
        i_bit_r <= i_mem_rdata[`RIC_CC_I_BIT];
      else if (i_mask_wr)
        i_bit_r <= i_mask_val;
    end
  end

  // Single-entry latch; a fresh edge outranks a clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      ext_pend_r <= 1'b0;
    else if (i_ce)
    begin
      if (in_rst)
        ext_pend_r <= 1'b0;
      else if (ext_edge)
        ext_pend_r <= 1'b1;
      else if (trig_chg || (svc_start && base_nxt == `RIC_VEC_EXT))
        ext_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      wake_pend_r <= 1'b0;
    else if (i_ce)
    begin
      if (in_rst)
        wake_pend_r <= 1'b0;
      else if (wake_set)
        wake_pend_r <= 1'b1;
      else if (svc_start && base_nxt == `RIC_VEC_WAKE)
        wake_pend_r <= 1'b0;
    end
  end

  // Trigger bits locked while unmasked; watchdog bit only set by software
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || (i_ce && in_rst))
    begin
      rise_sel_r <= 1'b0;
      fall_sel_r <= 1'b0;
      sm_r <= 1'b0;
      watchdog_control_bit_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_misc_wr && i_bit_r)
      begin
        rise_sel_r <= i_misc_wdata[`RIC_MISC_RISE_BIT];
        fall_sel_r <= i_misc_wdata[`RIC_MISC_FALL_BIT];
      end
      if (state_nxt == ST_HALT)
        sm_r <= 1'b0;
      else if (i_misc_wr)
        sm_r <= i_misc_wdata[`RIC_MISC_SM_BIT];
      if (i_misc_wr && i_misc_wdata[`RIC_MISC_WATCHDOG_CONTROL_BIT_BIT])
        watchdog_control_bit_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack and vector traffic
  always_comb
  begin
    push_data = {3'h7, i_cc[4], i_bit_r, i_cc[2:0]};
    case (step_r)
      3'h0: push_data = i_pc[7:0];
      3'h1: push_data = {3'h0, i_pc[12:8]};
      3'h2: push_data = i_x;
      3'h3: push_data = i_a;
      default: push_data = {3'h7, i_cc[4], i_bit_r, i_cc[2:0]};
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      sp_r <= `RIC_SP_RESET;
    else if (i_ce)
    begin
      if (in_rst)
        sp_r <= `RIC_SP_RESET;
      else if (state_r == ST_PUSH)
        sp_r <= sp_r - 8'h01;
      else if (state_r == ST_POP && step_r < 3'h5)
        sp_r <= sp_r + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= 13'h0000;
      o_mem_wdata <= 8'h00;
    end
    else if (i_ce)
    begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      case (state_r)
        ST_PUSH:
        begin
          o_mem_wr <= 1'b1;
          o_mem_addr <= {5'h00, sp_r};
          o_mem_wdata <= push_data;
        end
        ST_FETCH_A:
        begin
          o_mem_rd <= 1'b1;
          o_mem_addr <= base_r;
        end
        ST_FETCH_B:
        begin
          o_mem_rd <= 1'b1;
          o_mem_addr <= base_r | 13'h0001;
        end
        ST_POP:
          if (step_r < 3'h5)
          begin
            o_mem_rd <= 1'b1;
            o_mem_addr <= {5'h00, sp_r + 8'h01};
          end
        default: o_mem_rd <= 1'b0;
      endcase
    end
  end

  // Read data arrives the cycle after the read strobe
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_pc <= `RIC_VEC_RESET;
      o_x <= 8'h00;
      o_a <= 8'h00;
      o_cc <= 5'h08;
      o_pc_load <= 1'b0;
      o_regs_restore <= 1'b0;
    end
    else if (i_ce)
    begin
      o_pc_load <= state_r == ST_FETCH_D;
      o_regs_restore <= state_r == ST_POP && step_r == `RIC_POP_LAST;
      if (state_r == ST_FETCH_C)
        o_pc[12:8] <= i_mem_rdata[4:0];
      if (state_r == ST_FETCH_D)
        o_pc[7:0] <= i_mem_rdata;
      if (state_r == ST_POP)
      begin
        case (step_r)
          3'h2: o_cc <= i_mem_rdata[4:0];
          3'h3: o_a <= i_mem_rdata;
          3'h4: o_x <= i_mem_rdata;
          3'h5: o_pc[12:8] <= i_mem_rdata[4:0];
          3'h6: o_pc[7:0] <= i_mem_rdata;
          default: o_a <= o_a;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_reset_pin_o = 1'b0;
  assign o_reset_pin_oe = state_r == ST_POR || watchdog_control_bit_cnt_r != 2'h0;
  assign o_sp = sp_r;
  assign o_int_mask = i_bit_r;
  assign o_rising_trigger_select = rise_sel_r;
  assign o_falling_trigger_select = fall_sel_r;
  assign o_slow_clock_bit = sm_r;
  assign o_watchdog_control_bit = watchdog_control_bit_r;
  assign o_sys_reset = in_rst;
  assign o_timer_preset = `RIC_TMR_RESET;
  assign o_cpu_hold = state_r != ST_RUN;
  assign o_clk_stop = state_r == ST_POR || state_r == ST_HALT || state_r == ST_WAKE;
  assign o_wait_latch = state_r == ST_WAIT;
  assign o_halt_latch = state_r == ST_HALT || state_r == ST_WAKE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk iff i_ce);
  endclocking
  default disable iff (i_rst);

  logic quiet;
  assign quiet = pin_hi && !sup_rise;

  a_watchdog_control_bit_drive: assert property (i_watchdog_control_bit_expire |=> o_reset_pin_oe [*2])
    else $error("watchdog did not drive reset pin for two cycles");
  a_reset_vec: assert property (state_r == ST_RSTHOLD && quiet |=> state_r == ST_FETCH_A
    ##1 (o_mem_rd && o_mem_addr == `RIC_VEC_RESET)
    ##1 (o_mem_rd && o_mem_addr == 13'h1fff))
    else $error("reset vector fetch wrong");
  a_por_delay: assert property (state_r == ST_RSTHOLD && $past(state_r) == ST_POR
    |-> $past(dly_cnt_r) == CW'(POR_CYCLES - 1))
    else $error("power-on delay length wrong");
  a_pin_hold: assert property (state_r == ST_RSTHOLD && !pin_hi && !sup_rise
    |=> state_r == ST_RSTHOLD)
    else $error("left reset while pin low");
  a_push_seq: assert property (state_r == ST_PUSH && step_r == 3'h0 && quiet
    |=> o_mem_wr [*4] ##1 (o_mem_wr && i_bit_r))
    else $error("stacking sequence wrong");
  a_return_from_interrupt_mask: assert property (o_regs_restore |-> o_int_mask == o_cc[`RIC_CC_I_BIT])
    else $error("mask not restored from stack");
  a_ext_prio: assert property (run_end && !i_trap_exec && !i_return_from_interrupt &&
    !i_halt_exec && !i_wait_exec && !i_bit_r && ext_req && quiet
    |=> state_r == ST_PUSH && base_r == `RIC_VEC_EXT)
    else $error("external request not granted first");
  a_trap_first: assert property (run_end && i_trap_exec && quiet
    |=> state_r == ST_PUSH && base_r == `RIC_VEC_TRAP)
    else $error("trap not taken");
  a_masked_hold: assert property (run_end && i_bit_r && !i_trap_exec &&
    !i_return_from_interrupt && !i_halt_exec && !i_wait_exec && quiet
    |=> state_r == ST_RUN)
    else $error("maskable taken while masked");
  a_trig_locked: assert property (i_misc_wr && !i_bit_r && !in_rst
    |=> $stable(trig))
    else $error("trigger select changed while unmasked");
  a_trig_drop: assert property (trig_chg && !ext_edge && !in_rst |=> !ext_pend_r)
    else $error("pending kept across trigger change");
  a_halt_clr: assert property (run_end && i_halt_exec && !i_trap_exec &&
    !i_return_from_interrupt && !watchdog_control_bit_r && quiet |=> state_r == ST_HALT && !i_bit_r)
    else $error("halt entry wrong");
  a_wake_delay: assert property ((state_r == ST_PUSH || state_r == ST_RUN) &&
    $past(state_r) == ST_WAKE |-> $past(dly_cnt_r) == CW'(POR_CYCLES - 1))
    else $error("halt exit delay wrong");

  c_trap: cover property (run_end && i_trap_exec ##1 state_r == ST_PUSH);
  c_return_from_interrupt: cover property (o_regs_restore);
  c_por_run: cover property (state_r == ST_FETCH_D ##1 state_r == ST_RUN);
  c_halt_wake: cover property (state_r == ST_WAKE ##1 state_r == ST_PUSH);
endmodule // ric_reset_int_ctrl

// >>> bench/ric_src_model.sv
`timescale 1ns/1ps
module ric_src_model (
  input wire logic i_core_clk,
  input wire logic i_pin_oe,
  output logic o_reset_pin_n,
  output logic o_ext_int
);
  logic drive_n = 1'b1;
  // Wired reset line: either party pulls low, pull-up otherwise
  assign o_reset_pin_n = (i_pin_oe || !drive_n) ? 1'b0 : 1'b1;
  initial o_ext_int = 1'b1;
  task automatic pull_reset(input int n);
    @(negedge i_core_clk);
    drive_n = 1'b0;
    // Held far beyond one and a half clocks
    repeat (n) @(negedge i_core_clk);
    drive_n = 1'b1;
  endtask
  task automatic pulse_ext(input int n);
    @(negedge i_core_clk);
    o_ext_int = 1'b0;
    repeat (n) @(negedge i_core_clk);
    o_ext_int = 1'b1;
    // Quiet gap so no second pulse lands inside a service
    repeat (25) @(negedge i_core_clk);
  endtask
endmodule // ric_src_model

// >>> bench/ric_reset_int_ctrl_test.sv
`timescale 1ns/1ps
`include "ric_defs.svh"
module ric_reset_int_ctrl_test;
  import ric_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_supply_ok = 1'b1, i_osc_active = 1'b1;
  logic i_watchdog_control_bit_expire = 1'b0, i_tmr_capture = 1'b0, i_tmr_compare = 1'b0, i_tmr_overflow = 1'b0;
  logic i_instr_end = 1'b0, i_trap_exec = 1'b0, i_return_from_interrupt = 1'b0, idle_q = 1'b0;
  logic i_wait_exec = 1'b0, i_halt_exec = 1'b0, i_mask_wr = 1'b0, i_mask_val = 1'b0;
  logic i_misc_wr = 1'b0, i_reset_pin_n, i_ext_int_pin;
  logic [5:0] i_wake_port_pins = 6'h3f, i_wake_src_en = 6'h01;
  logic [4:0] i_cc = 5'h15, o_cc;
  ric_byte_t i_misc_wdata = 8'h00, i_x = 8'h11, i_a = 8'h22, i_mem_rdata = 8'h00;
  ric_addr_t i_pc = 13'h0123, o_mem_addr, o_pc;
  ric_byte_t o_mem_wdata, o_x, o_a, o_sp;
  logic o_reset_pin_o, o_reset_pin_oe, o_mem_rd, o_mem_wr, o_pc_load, o_regs_restore, o_int_mask;
  logic o_rising_trigger_select, o_falling_trigger_select, o_slow_clock_bit;
  logic o_watchdog_control_bit, o_sys_reset, o_cpu_hold, o_clk_stop, o_wait_latch, o_halt_latch;
  logic [15:0] o_timer_preset;
  int n_errors = 0, tests_run = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  ric_reset_int_ctrl #(.POR_CYCLES(8)) ric_reset_int_ctrl_inst (.*);
  ric_src_model ric_src_model_inst (.i_core_clk(i_core_clk), .i_pin_oe(o_reset_pin_oe),
    .o_reset_pin_n(i_reset_pin_n), .o_ext_int(i_ext_int_pin));
  always #5 i_core_clk = ~i_core_clk;
  // Vector area answers its own low address byte; stack area is a real RAM
  ric_byte_t stk [256];
  always @(posedge i_core_clk)
  begin
    if (o_mem_wr)
      stk[o_mem_addr[7:0]] <= o_mem_wdata;
    i_mem_rdata <= o_mem_addr[12] ? o_mem_addr[7:0] : stk[o_mem_addr[7:0]];
  end
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Vector pair: even byte bits 4:0 give PC high, odd byte gives PC low
  function automatic logic [15:0] vec(input logic [12:0] v);
    return {3'h0, v[4:0], v[7:0] | 8'h01};
  endfunction
  // Bounded wait for a load or restore pulse, then judge the PC
  task automatic wait_for(input bit restore, input logic [15:0] exp_pc);
    int k;
    k = 0;
    @(negedge i_core_clk);
    while (((restore ? o_regs_restore : o_pc_load) !== 1'b1) && k < 300)
    begin
      @(negedge i_core_clk);
      k++;
    end
    // A missed strobe must not pass on a stale PC
    check({(restore ? o_regs_restore : o_pc_load), o_cpu_hold}, 2'b10);
    check({3'h0, o_pc}, exp_pc);
  endtask
  task automatic boundary(ref logic q);
    @(negedge i_core_clk);
    i_instr_end = 1'b1;
    q = 1'b1;
    @(negedge i_core_clk);
    i_instr_end = 1'b0;
    q = 1'b0;
  endtask
  task automatic set_mask(input logic v);
    @(negedge i_core_clk);
    i_mask_wr = 1'b1;
    i_mask_val = v;
    @(negedge i_core_clk);
    i_mask_wr = 1'b0;
  endtask
  task automatic misc(input ric_byte_t d);
    @(negedge i_core_clk);
    i_misc_wr = 1'b1;
    i_misc_wdata = d;
    @(negedge i_core_clk);
    i_misc_wr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    repeat (8) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_core_clk);
    check({o_sys_reset, o_cpu_hold, o_clk_stop}, 3'b111);
    check({o_reset_pin_oe, o_reset_pin_o}, 2'b10);
    check({o_sp, 7'h00, o_int_mask}, 16'hff01);
    check(o_timer_preset, 16'hfffc);
    wait_for(1'b0, vec(`RIC_VEC_RESET));
  endtask
  task automatic t_trap_ret;
    set_mask(1'b0);
    boundary(i_trap_exec);
    wait_for(1'b0, vec(`RIC_VEC_TRAP));
    check({o_sp, 7'h00, o_int_mask}, 16'hfa01);
    boundary(i_trap_exec);
    wait_for(1'b0, vec(`RIC_VEC_TRAP));
    check({o_sp, 7'h00, o_int_mask}, 16'hf501);
    boundary(i_return_from_interrupt);
    wait_for(1'b1, 16'h0123);
    check({o_sp, 2'h0, o_cc, o_int_mask}, 16'hfa3b);
    boundary(i_return_from_interrupt);
    wait_for(1'b1, 16'h0123);
    check({o_x, o_a}, 16'h1122);
    check({o_sp, 2'h0, o_cc, o_int_mask}, 16'hff2a);
  endtask
  task automatic t_trigger;
    set_mask(1'b1);
    misc(8'h20);
    check({o_rising_trigger_select, o_falling_trigger_select}, 2'b01);
    set_mask(1'b0);
    misc(8'h40);
    check({o_rising_trigger_select, o_falling_trigger_select}, 2'b01);
  endtask
  task automatic t_ext_pending;
    set_mask(1'b1);
    ric_src_model_inst.pulse_ext(3);
    set_mask(1'b0);
    boundary(idle_q);
    wait_for(1'b0, vec(`RIC_VEC_EXT));
  endtask
  task automatic t_priority;
    @(negedge i_core_clk);
    {i_tmr_capture, i_tmr_compare, i_tmr_overflow} = 3'b111;
    i_wake_port_pins = 6'h3e;
    set_mask(1'b0);
    boundary(idle_q);
    wait_for(1'b0, vec(`RIC_VEC_CAP));
    {i_tmr_capture, i_tmr_compare, i_tmr_overflow} = 3'b000;
    i_wake_port_pins = 6'h3f;
  endtask
  task automatic t_resets;
    ric_src_model_inst.pull_reset(6);
    check(o_sys_reset, 1'b1);
    wait_for(1'b0, vec(`RIC_VEC_RESET));
    check({o_sp, 7'h00, o_int_mask}, 16'hff01);
    @(negedge i_core_clk);
    i_watchdog_control_bit_expire = 1'b1;
    @(negedge i_core_clk);
    i_watchdog_control_bit_expire = 1'b0;
    check(o_reset_pin_oe, 1'b1);
    wait_for(1'b0, vec(`RIC_VEC_RESET));
  endtask
  task automatic t_low_power;
    boundary(i_wait_exec);
    check({o_wait_latch, o_int_mask}, 2'b10);
    i_tmr_overflow = 1'b1;
    wait_for(1'b0, vec(`RIC_VEC_OVF));
    i_tmr_overflow = 1'b0;
    misc(8'h02);
    boundary(i_halt_exec);
    check({o_halt_latch, o_clk_stop, o_int_mask, o_slow_clock_bit}, 4'b1100);
    i_wake_port_pins = 6'h3e;
    wait_for(1'b0, vec(`RIC_VEC_WAKE));
    i_wake_port_pins = 6'h3f;
    misc(8'h01);
    boundary(i_halt_exec);
    check({o_reset_pin_oe, o_watchdog_control_bit}, 2'b11);
    wait_for(1'b0, vec(`RIC_VEC_RESET));
    check(o_watchdog_control_bit, 1'b0);
  endtask
  initial
  begin
    t_power_on();
    t_trap_ret();
    t_trigger();
    t_ext_pending();
    t_priority();
    t_resets();
    t_low_power();
    summarize();
  end
endmodule // ric_reset_int_ctrl_test
